// ---- dmr_pkg.sv ----
/*
  Shared constants and types for the mode register zero/one block.
  Assumes a 200 MHz core clock; all other encodings but the recovery cycle lookup live here.
*/
package dmr_pkg;

  // mode register addresses on the command operands
  localparam logic [5:0] MR_ADDR_STATUS = 6'h00;
  localparam logic [5:0] MR_ADDR_CONFIG = 6'h01;

  // register zero field positions
  localparam int unsigned MR0_REFRESH_BIT = 0;
  localparam int unsigned MR0_LATENCY_BIT = 1;
  localparam int unsigned MR0_SELFTEST_LO = 3;
  localparam int unsigned MR0_TERM_BIT = 7;

  // self-test result codes
  localparam logic [1:0] ZQ_NOT_SUPPORTED = 2'h0;
  localparam logic [1:0] ZQ_GND_OR_FLOAT = 2'h1;
  localparam logic [1:0] ZQ_SHORT_IO = 2'h2;
  localparam logic [1:0] ZQ_RESISTOR_OK = 2'h3;

  // burst length codes
  localparam logic [1:0] BURST_FIXED_16 = 2'h0;
  localparam logic [1:0] BURST_FIXED_32 = 2'h1;
  localparam logic [1:0] BURST_ON_THE_FLY = 2'h2;

  // register one after reset: defaults, write preamble of two clocks
  localparam logic [7:0] MR1_RESET = 8'h04;

  // calibration latch time and its cycle count, rounded up
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned CAL_LATCH_NS = 30;
  localparam int unsigned CAL_LATCH_CYC = (CAL_LATCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CAL_CNT_W = 8;

  // register one layout, msb first as on the operands
  typedef struct packed {
    logic read_postamble_len;
    logic [2:0] write_recovery_cycles;
    logic rd_preamble_toggle;
    logic wr_preamble_long;
    logic [1:0] burst_len_select;
  } dmr_mr1_type;

  // command decoded outside, presented on the link clock
  typedef struct packed {
    logic mrw;
    logic mrr;
    logic cal_start;
    logic cal_latch;
    logic [5:0] addr;
    logic [7:0] op;
  } dmr_cmd_type;

  // self-test sequence, gray along the usual path
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_STARTED = 2'b01,
    CAL_LATCHING = 2'b11,
    CAL_DONE = 2'b10
  } dmr_cal_state_type;

endpackage

// ---- dmr_mode_regs.sv ----
/*
  Mode registers zero and one of one DRAM channel, with two set-point
  copies of register one and the calibration-pin self-test sequencer.
  Assumes the command decoder outside presents decoded commands that are
  stable around the rising edge of the slow link clock; all pins but rst_b are
  asynchronous to clk and are synchronised here.
*/
// Summary of operation
// - registers reached only by mode read/write commands
// - bits 4:3 of register zero report self-test
// - self-test valid after start, latch, latch time
// - reset clears stored self-test result
// - calibration pin tied to ground reads 01
// - assembly error: factory trim, ignore calibration commands
// - bit 7 of register zero shows termination
// - bits 1:0 of register one select burst length
// - bit 3 selects static or toggling read preamble
// - bit 7 selects 0.5 or 1.5 clock postamble
// - write-only bits 6:4 give write recovery cycles
// - read/write access the write-select set-point copy
// - device operates from the operate-select copy
// - inactive copy ignored, rewritable without disturbance
`timescale 1ns/1ps
module dmr_mode_regs #(
  parameter bit SELFTEST_SUPPORTED = 1'b1,
  parameter bit MODIFIED_REFRESH_ONLY = 1'b0
) (
  input wire logic clk, // core clock, 200 MHz
  input wire logic rst_b, // synchronous reset, active low
  input wire logic link_ck, // command clock from the controller
  input wire dmr_pkg::dmr_cmd_type link_cmd, // decoded command, link domain
  input wire logic setpoint_write_select, // write-select bit of register thirteen
  input wire logic setpoint_operate_select, // operate-select bit of register thirteen
  input wire logic [1:0] zq_sense, // analog sense code of calibration pin
  input wire logic ca_termination_pad, // termination pad status
  output logic [7:0] mrr_data_r, // mode register read data
  output logic mrr_valid_r, // one-cycle pulse with read data
  output logic [1:0] burst_len_select_r, // operating burst length code
  output logic rd_preamble_toggle_r, // operating read preamble type
  output logic wr_preamble_long_r, // operating write preamble
  output logic read_postamble_len_r, // operating postamble, 1 = 1.5 clocks
  output logic [5:0] write_recovery_cycles_r, // operating recovery count
  output logic factory_trim_r, // drive impedance uses factory trim
  output logic selftest_valid_r // self-test result is valid
);

  localparam int unsigned PIN_W = $bits(dmr_pkg::dmr_cmd_type) + 6;

  // synchroniser: first stage read only by the second
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic link_ck_d_r;

  assign pin_raw = {link_ck, link_cmd, setpoint_write_select, setpoint_operate_select,
                    zq_sense, ca_termination_pad};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      link_ck_d_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      link_ck_d_r <= pin_s2_r[PIN_W-1];
    end
  end

  wire logic link_ck_s = pin_s2_r[PIN_W-1];
  wire dmr_pkg::dmr_cmd_type cmd_s = pin_s2_r[PIN_W-2:5];
  wire logic sp_wr_s = pin_s2_r[4];
  wire logic sp_op_s = pin_s2_r[3];
  wire logic [1:0] zq_code_s = pin_s2_r[2:1];
  wire logic ca_term_s = pin_s2_r[0];

  // commands sampled on the rising link edge; data travelled the same two stages
  wire logic link_rise = link_ck_s & ~link_ck_d_r;
  wire logic take_mrw = link_rise & cmd_s.mrw;
  wire logic take_mrr = link_rise & cmd_s.mrr;
  wire logic hit_status = cmd_s.addr == dmr_pkg::MR_ADDR_STATUS;
  wire logic hit_config = cmd_s.addr == dmr_pkg::MR_ADDR_CONFIG;

  // recovery cycle lookup
  function automatic logic [5:0] recovery_count(input logic [2:0] code);
    case (code)
      3'h0: recovery_count = 6'h06;
      3'h1: recovery_count = 6'h0A;
      3'h2: recovery_count = 6'h10;
      3'h3: recovery_count = 6'h14;
      3'h4: recovery_count = 6'h18;
      3'h5: recovery_count = 6'h1E;
      3'h6: recovery_count = 6'h22;
      default: recovery_count = 6'h28;
    endcase
  endfunction

  // two set-point copies of register one
  dmr_pkg::dmr_mr1_type cfg_r [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_setpoint
      wire logic wr_this = take_mrw & hit_config & (sp_wr_s == 1'(g));
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          cfg_r[g] <= dmr_pkg::MR1_RESET;
        end else if (wr_this) begin
          cfg_r[g] <= cmd_s.op;
        end
      end
    end
  endgenerate

  wire dmr_pkg::dmr_mr1_type cfg_wr_sel = cfg_r[sp_wr_s];
  wire dmr_pkg::dmr_mr1_type cfg_op_sel = cfg_r[sp_op_s];

  // self-test sequencer
  dmr_pkg::dmr_cal_state_type st_r;
  dmr_pkg::dmr_cal_state_type st_nxt;
  logic [dmr_pkg::CAL_CNT_W-1:0] cnt_r;
  logic [dmr_pkg::CAL_CNT_W-1:0] cnt_nxt;
  logic [1:0] selftest_r;
  logic [1:0] selftest_nxt;
  logic factory_trim_nxt;

  // calibration commands are dropped once factory trim has taken over
  wire logic cal_start_ok = link_rise & cmd_s.cal_start & ~factory_trim_r;
  wire logic cal_latch_ok = link_rise & cmd_s.cal_latch & ~factory_trim_r;
  wire logic latch_done = cnt_r == dmr_pkg::CAL_CNT_W'(dmr_pkg::CAL_LATCH_CYC - 1);
  wire logic [1:0] measured = SELFTEST_SUPPORTED ? zq_code_s : dmr_pkg::ZQ_NOT_SUPPORTED;
  wire logic assembly_err = (measured == dmr_pkg::ZQ_GND_OR_FLOAT) |
                            (measured == dmr_pkg::ZQ_SHORT_IO);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    selftest_nxt = selftest_r;
    factory_trim_nxt = factory_trim_r;
    case (st_r)
      dmr_pkg::CAL_IDLE, dmr_pkg::CAL_DONE: begin
        if (cal_start_ok) begin
          st_nxt = dmr_pkg::CAL_STARTED;
        end
      end
      dmr_pkg::CAL_STARTED: begin
        if (cal_latch_ok) begin
          st_nxt = dmr_pkg::CAL_LATCHING;
          cnt_nxt = '0;
        end
      end
      dmr_pkg::CAL_LATCHING: begin
        cnt_nxt = cnt_r + 1'b1;
        if (latch_done) begin
          st_nxt = dmr_pkg::CAL_DONE;
          selftest_nxt = measured;
          factory_trim_nxt = assembly_err;
        end
      end
      default: begin
        st_nxt = dmr_pkg::CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= dmr_pkg::CAL_IDLE;
      cnt_r <= '0;
      selftest_r <= dmr_pkg::ZQ_NOT_SUPPORTED;
      factory_trim_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      selftest_r <= selftest_nxt;
      factory_trim_r <= factory_trim_nxt;
    end
  end

  // read data; recovery bits are write-only and read as zero
  logic [7:0] status_word;
  always_comb begin
    status_word = 8'h00;
    status_word[dmr_pkg::MR0_REFRESH_BIT] = MODIFIED_REFRESH_ONLY;
    status_word[dmr_pkg::MR0_LATENCY_BIT] = 1'b0;
    status_word[dmr_pkg::MR0_SELFTEST_LO +: 2] = selftest_r;
    status_word[dmr_pkg::MR0_TERM_BIT] = ca_term_s;
  end

  wire logic [7:0] config_word = {cfg_wr_sel.read_postamble_len, 3'h0,
                                  cfg_wr_sel.rd_preamble_toggle, cfg_wr_sel.wr_preamble_long,
                                  cfg_wr_sel.burst_len_select};
  wire logic read_hit = take_mrr & (hit_status | hit_config);
  wire logic [7:0] read_word = hit_status ? status_word : config_word;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mrr_data_r <= 8'h00;
      mrr_valid_r <= 1'b0;
    end else begin
      mrr_valid_r <= read_hit;
      if (read_hit) begin
        mrr_data_r <= read_word;
      end
    end
  end

  // operating fields follow only the active copy
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      burst_len_select_r <= dmr_pkg::BURST_FIXED_16;
      rd_preamble_toggle_r <= 1'b0;
      wr_preamble_long_r <= 1'b1;
      read_postamble_len_r <= 1'b0;
      write_recovery_cycles_r <= 6'h06;
      selftest_valid_r <= 1'b0;
    end else begin
      burst_len_select_r <= cfg_op_sel.burst_len_select;
      rd_preamble_toggle_r <= cfg_op_sel.rd_preamble_toggle;
      wr_preamble_long_r <= cfg_op_sel.wr_preamble_long;
      read_postamble_len_r <= cfg_op_sel.read_postamble_len;
      write_recovery_cycles_r <= recovery_count(cfg_op_sel.write_recovery_cycles);
      selftest_valid_r <= st_nxt == dmr_pkg::CAL_DONE;
    end
  end

  // checks
  AST_UNMAPPED_SILENT: assert property (@(posedge clk) disable iff (!rst_b)
    (take_mrr && !hit_status && !hit_config) |=> !mrr_valid_r)
    else $error("read of unmapped register answered");

  AST_STATUS_SELFTEST: assert property (@(posedge clk) disable iff (!rst_b)
    (take_mrr && hit_status) |=> (mrr_valid_r && mrr_data_r[4:3] == $past(selftest_r)))
    else $error("self-test field wrong in status read");

  AST_RESULT_ONLY_DONE: assert property (@(posedge clk) disable iff (!rst_b)
    !$stable(selftest_r) |-> ($past(st_r) == dmr_pkg::CAL_LATCHING && $past(latch_done)))
    else $error("self-test result changed outside latch completion");

  AST_LATCH_WAIT: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(st_r == dmr_pkg::CAL_LATCHING) |-> (st_r == dmr_pkg::CAL_LATCHING) [*6])
    else $error("latch time cut short");

  AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> (selftest_r == 2'h0 && !selftest_valid_r && !factory_trim_r))
    else $error("self-test result survived reset");

  AST_CODE_FROM_PIN: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == dmr_pkg::CAL_LATCHING && latch_done && SELFTEST_SUPPORTED)
      |=> selftest_r == $past(zq_code_s))
    else $error("self-test code not taken from pin sense");

  AST_TRIM_IGNORES_CAL: assert property (@(posedge clk) disable iff (!rst_b)
    (factory_trim_r && st_r == dmr_pkg::CAL_DONE) |=> st_r == dmr_pkg::CAL_DONE)
    else $error("calibration command accepted under factory trim");

  AST_TERM_BIT: assert property (@(posedge clk) disable iff (!rst_b)
    (take_mrr && hit_status) |=> mrr_data_r[7] == $past(ca_term_s))
    else $error("termination bit wrong");

  AST_WRITE_SEL_COPY: assert property (@(posedge clk) disable iff (!rst_b)
    (take_mrw && hit_config) |=> cfg_r[$past(sp_wr_s)] == $past(cmd_s.op))
    else $error("write missed the selected set point");

  AST_INACTIVE_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
    (take_mrw && hit_config && sp_wr_s != sp_op_s && $stable(sp_op_s))
      ##1 $stable(sp_op_s) |=> $stable(burst_len_select_r) && $stable(write_recovery_cycles_r))
    else $error("inactive set-point write disturbed operation");

  AST_RECOVERY_DEFAULT: assert property (@(posedge clk) disable iff (!rst_b)
    (take_mrw && hit_config && sp_wr_s == sp_op_s && cmd_s.op[6:4] == 3'h0)
      ##1 (sp_op_s == $past(sp_op_s)) |=> write_recovery_cycles_r == 6'h06)
    else $error("recovery count for code zero not six");

  // link edges are at least six core cycles apart, so an answer never stretches
  AST_ANSWER_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_b)
    mrr_valid_r |=> !mrr_valid_r)
    else $error("read answer stood longer than one cycle");

  AST_RECOVERY_READS_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
    (take_mrr && hit_config) |=> (mrr_valid_r && mrr_data_r[6:4] == 3'h0))
    else $error("write-only recovery bits visible on read");

  AST_STATUS_READ_ONLY: assert property (@(posedge clk) disable iff (!rst_b)
    (take_mrw && hit_status && st_r != dmr_pkg::CAL_LATCHING) |=> $stable(selftest_r))
    else $error("write to status register changed self-test field");

  AST_START_DROPS_VALID: assert property (@(posedge clk) disable iff (!rst_b)
    (st_r == dmr_pkg::CAL_STARTED) |-> !selftest_valid_r)
    else $error("self-test valid while a new sequence runs");

  AST_TRIM_ON_ASSEMBLY_ERR: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(factory_trim_r) |-> (selftest_r == dmr_pkg::ZQ_GND_OR_FLOAT
      || selftest_r == dmr_pkg::ZQ_SHORT_IO))
    else $error("factory trim taken without assembly error");

endmodule // dmr_mode_regs

// ---- dmr_ctrl_model.sv ----
/*
  Controller model: sends one decoded command per link clock frame.
  Assumes the caller invokes send just after a falling core clock edge.
*/
`timescale 1ns/1ps
module dmr_ctrl_model (
  output logic link_ck, // link clock, still between frames
  output dmr_pkg::dmr_cmd_type link_cmd // decoded command
);
  initial begin
    link_ck = 1'b0;
    link_cmd = '0;
  end
  // only mode read/write carry register traffic
  task automatic send(input dmr_pkg::dmr_cmd_type c);
    link_cmd = c;
    // rise kept off the core edges so the synchroniser sees a clean level
    #61.2;
    link_ck = 1'b1;
    #62.5;
    link_ck = 1'b0;
    // strobes dropped, operands scrambled so stale data is never mistaken for valid
    link_cmd = {4'h0, ~c[13:0]};
    #1.3;
  endtask
endmodule // dmr_ctrl_model

// ---- tb_dmr_mode_regs.sv ----
/*
  Self-checking bench for mode registers zero and one.
  Assumes dmr_ctrl_model drives the link; reads are checked by a monitor.
*/
`timescale 1ns/1ps
module tb_dmr_mode_regs;
  logic clk, rst_b, link_ck, ws, os, pad, fac, stv, rdv, rdp, wrp, pst;
  dmr_pkg::dmr_cmd_type link_cmd;
  logic [1:0] zq, blen;
  logic [7:0] rdd, v, last;
  logic [5:0] rec;
  logic [7:0] exp_q[$];
  int err_total, checks, cyc;
  localparam logic [5:0] REC[8] = '{6'h06, 6'h0A, 6'h10, 6'h14, 6'h18, 6'h1E, 6'h22, 6'h28};
  dmr_ctrl_model u_ctrl (.link_ck(link_ck), .link_cmd(link_cmd));
  dmr_mode_regs u_dut (.clk(clk), .rst_b(rst_b), .link_ck(link_ck), .link_cmd(link_cmd),
    .setpoint_write_select(ws), .setpoint_operate_select(os), .zq_sense(zq),
    .ca_termination_pad(pad), .mrr_data_r(rdd), .mrr_valid_r(rdv), .burst_len_select_r(blen),
    .rd_preamble_toggle_r(rdp), .wr_preamble_long_r(wrp), .read_postamble_len_r(pst),
    .write_recovery_cycles_r(rec), .factory_trim_r(fac), .selftest_valid_r(stv));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic test_done();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] o);
    u_ctrl.send(dmr_pkg::dmr_cmd_type'{1'b1, 1'b0, 1'b0, 1'b0, a, o});
    tick(2);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    u_ctrl.send(dmr_pkg::dmr_cmd_type'{1'b0, 1'b1, 1'b0, 1'b0, a, 8'h00});
    tick(2);
  endtask
  task automatic cal(input bit s, input bit l);
    u_ctrl.send(dmr_pkg::dmr_cmd_type'{1'b0, 1'b0, s, l, 6'h00, 8'h00});
    tick(8);
  endtask
  task automatic chk_op(input logic [7:0] e);
    chk({3'h0, pst, rdp, wrp, blen}, {3'h0, e[7], e[3], e[2], e[1:0]});
    chk({2'h0, rec}, {2'h0, REC[e[6:4]]});
  endtask
  function automatic logic [7:0] mr0(input logic [1:0] st);
    return {pad, 2'b00, st, 3'b000};
  endfunction
  // mid-cycle look: the answer pulse stands from one rising edge to the next
  always @(negedge clk) begin
    if (rdv === 1'b1) begin
      // a pulse with nothing expected is an unasked answer
      if (exp_q.size() == 0) chk({7'h0, rdv}, 8'h00);
      else chk(rdd, exp_q.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    rst_b = 1'b0;
    ws = 1'b0;
    os = 1'b0;
    zq = 2'h3;
    pad = 1'b0;
    void'($urandom(94));
    tick(10);
    rst_b = 1'b1;
    tick(5);
    chk_op(8'h04);
    chk({6'h0, stv, fac}, 8'h00);
    rd(6'h01, 8'h04);
    rd(6'h00, mr0(2'h0));
    $display("test reset defaults done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom());
      v[6:4] = 3'(i);
      v[1:0] = 2'(i);
      v[2] = 1'b1; // two-clock write preamble always programmed
      wr(6'h01, v);
      chk_op(v);
      rd(6'h01, v & 8'h8F);
    end
    last = v;
    $display("test field codes done");
    u_ctrl.send(dmr_pkg::dmr_cmd_type'{1'b0, 1'b1, 1'b0, 1'b0, 6'h05, 8'h00});
    pad = 1'($urandom());
    wr(6'h00, 8'hFF);
    tick(3);
    rd(6'h00, mr0(2'h0));
    $display("test refused access done");
    ws = 1'b1;
    tick(5);
    // inactive copy rewritten while operating
    wr(6'h01, 8'hB5);
    chk_op(last);
    rd(6'h01, 8'h85);
    os = 1'b1;
    tick(5);
    chk_op(8'hB5);
    ws = 1'b0;
    tick(5);
    rd(6'h01, last & 8'h8F);
    $display("test set points done");
    cal(1'b0, 1'b1);
    chk({7'h0, stv}, 8'h00);
    cal(1'b1, 1'b0);
    chk({7'h0, stv}, 8'h00);
    cal(1'b0, 1'b1);
    chk({6'h0, stv, fac}, 8'h02);
    rd(6'h00, mr0(2'h3));
    rst_b = 1'b0;
    tick(3);
    rst_b = 1'b1;
    tick(3);
    chk({7'h0, stv}, 8'h00);
    rd(6'h00, mr0(2'h0));
    zq = 2'h1;
    tick(5);
    cal(1'b1, 1'b0);
    cal(1'b0, 1'b1);
    chk({7'h0, fac}, 8'h01);
    rd(6'h00, mr0(2'h1));
    zq = 2'h3;
    tick(5);
    cal(1'b1, 1'b0);
    cal(1'b0, 1'b1);
    rd(6'h00, mr0(2'h1));
    // second assembly-error code, after a reset that clears the trim
    rst_b = 1'b0;
    zq = 2'h2;
    tick(3);
    rst_b = 1'b1;
    tick(5);
    chk({6'h0, stv, fac}, 8'h00);
    cal(1'b1, 1'b0);
    cal(1'b0, 1'b1);
    chk({6'h0, stv, fac}, 8'h03);
    rd(6'h00, mr0(2'h2));
    $display("test self-test done");
    tick(10);
    chk(8'(exp_q.size()), 8'h00);
    test_done();
  end
endmodule // tb_dmr_mode_regs
